// ===== hw/ivm_consts.svh
// constants of the interrupt vector mapper: offsets, fields, reset values
`ifndef IVM_CONSTS_SVH
`define IVM_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define IVM_OFS_CTRL 12'h000
`define IVM_OFS_TRAP 12'h004
`define IVM_OFS_EVT_STAT 12'h008
`define IVM_OFS_EVT_MASK 12'h00C
`define IVM_OFS_VEC_STAT 12'h010
`define IVM_OFS_FLAG 12'h040
`define IVM_OFS_ENABLE 12'h080
`define IVM_OFS_PRIO 12'h100

// ****************************************
// field positions and sizes
// ****************************************
`define IVM_ALT_BIT 15
`define IVM_NUM_REQ 98
`define IVM_NUM_FLAG_REGS 7
`define IVM_NUM_PRIO_REGS 25
`define IVM_TRAP_FIRST 1
`define IVM_TRAP_LAST 4
`define IVM_USER_VEC_OFS 8

// ****************************************
// vector table layout
// ****************************************
`define IVM_PRIMARY_BASE 24'h00_0004
`define IVM_ALT_DISTANCE 24'h00_0100
`define IVM_RESET_ADDR 24'h00_0000
`define IVM_TRAP_LEVEL 4'h8

// ****************************************
// request numbers of named sources
// ****************************************
`define IVM_IRQ_EXT0 0
`define IVM_IRQ_EXT1 20
`define IVM_IRQ_EXT2 29
`define IVM_IRQ_SER1_RX 11
`define IVM_IRQ_SER1_TX 12
`define IVM_IRQ_ADC_DONE 13
`define IVM_IRQ_SSP1_XFER 16
`define IVM_IRQ_SSP1_COLL 17
`define IVM_IRQ_SSP2_XFER 49
`define IVM_IRQ_SSP2_COLL 50
`define IVM_IRQ_CAL_CLOCK 62
`define IVM_IRQ_SER1_ERR 65
`define IVM_IRQ_CELL1 96
`define IVM_IRQ_CELL2 97
// remaining implemented sources
`define IVM_IMPL_BASE 98'h0_0001_E104_0000_0200_F84E_81EF

// ****************************************
// event status bits
// ****************************************
`define IVM_EVT_OFFER 0
`define IVM_EVT_TRAP 1

`endif

// ===== hw/ivm_pkg.sv
// types of the interrupt vector mapper
package ivm_pkg;
  `include "ivm_consts.svh"

  typedef enum logic [1:0] {
    IVM_IDLE = 2'b01,
    IVM_OFFER = 2'b10
  } ivm_state_t;

  typedef struct packed {
    ivm_state_t st;
    logic alt;
    logic [111:0] flag;
    logic [111:0] en;
    logic [97:0][2:0] prio;
    logic [4:1] trap;
    logic [1:0] evt;
    logic [1:0] evt_mask;
    logic req;
    logic [6:0] vnum;
    logic [23:0] vaddr;
    logic [3:0] vlvl;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ivm_regs_t;
endpackage

// ===== hw/ivm_mapper.sv
// interrupt vector mapper: flag/enable/priority registers, arbitration, vector fetch address
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module ivm_mapper
  import ivm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [97:0] periph_req,
  input wire logic external_request_zero,
  input wire logic external_request_one,
  input wire logic external_request_two,
  input wire logic [4:1] trap_event,
  input wire logic [3:0] cpu_level,
  input wire logic cpu_ack,
  output logic cpu_req,
  output logic [6:0] vec_num,
  output logic [23:0] vec_addr,
  output logic [3:0] vec_level,
  output logic irq
);

  // ****************************************
  // implemented request map
  // ****************************************
  localparam logic [97:0] IMPL = `IVM_IMPL_BASE
    | (98'(1) << `IVM_IRQ_EXT0) | (98'(1) << `IVM_IRQ_EXT1) | (98'(1) << `IVM_IRQ_EXT2)
    | (98'(1) << `IVM_IRQ_CELL1) | (98'(1) << `IVM_IRQ_CELL2)
    | (98'(1) << `IVM_IRQ_SER1_RX) | (98'(1) << `IVM_IRQ_SER1_TX)
    | (98'(1) << `IVM_IRQ_SER1_ERR) | (98'(1) << `IVM_IRQ_CAL_CLOCK)
    | (98'(1) << `IVM_IRQ_ADC_DONE)
    | (98'(1) << `IVM_IRQ_SSP1_XFER) | (98'(1) << `IVM_IRQ_SSP1_COLL)
    | (98'(1) << `IVM_IRQ_SSP2_XFER) | (98'(1) << `IVM_IRQ_SSP2_COLL);

  // ****************************************
  // functions
  // ****************************************
  // handler fetch address of a vector in the chosen table
  function automatic logic [23:0] vec_fetch(input logic alt, input logic [6:0] v);
    logic [23:0] base;
    base = alt ? (`IVM_PRIMARY_BASE + `IVM_ALT_DISTANCE) : `IVM_PRIMARY_BASE;
    return base + {16'h0000, v, 1'b0};
  endfunction

  // word index of an access inside a register group
  function automatic logic [5:0] word_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[7:2];
  endfunction

  ivm_regs_t r_q;
  ivm_regs_t r_d;
  logic [97:0] src;
  logic wr_done;
  logic acc;
  logic hit_trap;
  logic [2:0] trap_vec;
  logic hit_user;
  logic [6:0] user_n;
  logic [2:0] user_p;
  logic [5:0] idx;
  logic [31:0] rd;
  logic rd_err;

  // ****************************************
  // source collection
  // ****************************************
  // external pins replace periph_req at their request numbers
  always_comb begin
    src = periph_req & IMPL;
    src[`IVM_IRQ_EXT0] = external_request_zero;
    src[`IVM_IRQ_EXT1] = external_request_one;
    src[`IVM_IRQ_EXT2] = external_request_two;
  end

  // ****************************************
  // arbitration
  // ****************************************
  // traps win; lowest trap vector first
  always_comb begin
    hit_trap = 1'b0;
    trap_vec = 3'd0;
    for (int t = `IVM_TRAP_LAST; t >= `IVM_TRAP_FIRST; t--) begin
      if (r_q.trap[t]) begin
        hit_trap = 1'b1;
        trap_vec = 3'(t);
      end
    end
  end

  // highest level above cpu level; strict compare keeps the lower vector on ties
  always_comb begin
    hit_user = 1'b0;
    user_n = 7'd0;
    user_p = 3'd0;
    for (int n = 0; n < `IVM_NUM_REQ; n++) begin
      if (IMPL[n] && r_q.flag[n] && r_q.en[n] && ({1'b0, r_q.prio[n]} > cpu_level) &&
          (!hit_user || r_q.prio[n] > user_p)) begin
        hit_user = 1'b1;
        user_n = 7'(n);
        user_p = r_q.prio[n];
      end
    end
  end

  // ****************************************
  // register read decode
  // ****************************************
  always_comb begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    idx = 6'd0;
    if (paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (paddr == `IVM_OFS_CTRL) begin
      rd[`IVM_ALT_BIT] = r_q.alt;
    end else if (paddr == `IVM_OFS_TRAP) begin
      rd[4:1] = r_q.trap;
    end else if (paddr == `IVM_OFS_EVT_STAT) begin
      rd[1:0] = r_q.evt;
    end else if (paddr == `IVM_OFS_EVT_MASK) begin
      rd[1:0] = r_q.evt_mask;
    end else if (paddr == `IVM_OFS_VEC_STAT) begin
      rd = {4'h0, r_q.vlvl, r_q.vaddr};
    end else if (paddr >= `IVM_OFS_FLAG && paddr < `IVM_OFS_FLAG + 12'(4 * `IVM_NUM_FLAG_REGS)) begin
      idx = word_idx(paddr, `IVM_OFS_FLAG);
      rd[15:0] = r_q.flag[idx * 16 +: 16];
    end else if (paddr >= `IVM_OFS_ENABLE && paddr < `IVM_OFS_ENABLE + 12'(4 * `IVM_NUM_FLAG_REGS)) begin
      idx = word_idx(paddr, `IVM_OFS_ENABLE);
      rd[15:0] = r_q.en[idx * 16 +: 16];
    end else if (paddr >= `IVM_OFS_PRIO && paddr < `IVM_OFS_PRIO + 12'(4 * `IVM_NUM_PRIO_REGS)) begin
      idx = word_idx(paddr, `IVM_OFS_PRIO);
      for (int j = 0; j < 4; j++) begin
        if (idx * 4 + j < `IVM_NUM_REQ) begin
          rd[4 * j +: 3] = r_q.prio[idx * 4 + j];
        end
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_d = r_q;
    acc = psel && penable;
    wr_done = acc && pwrite && r_q.pready && !r_q.pslverr;
    // apb: one wait cycle, then answer held for one edge
    r_d.pready = acc && !r_q.pready;
    r_d.pslverr = acc && !r_q.pready && rd_err;
    if (acc && !r_q.pready) begin
      r_d.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    // software writes
    if (wr_done) begin
      if (paddr == `IVM_OFS_CTRL) begin
        r_d.alt = pwdata[`IVM_ALT_BIT];
      end else if (paddr == `IVM_OFS_TRAP) begin
        r_d.trap = pwdata[4:1];
      end else if (paddr == `IVM_OFS_EVT_STAT) begin
        r_d.evt = r_q.evt & ~pwdata[1:0];
      end else if (paddr == `IVM_OFS_EVT_MASK) begin
        r_d.evt_mask = pwdata[1:0];
      end else if (paddr >= `IVM_OFS_FLAG && paddr < `IVM_OFS_FLAG + 12'(4 * `IVM_NUM_FLAG_REGS)) begin
        r_d.flag[word_idx(paddr, `IVM_OFS_FLAG) * 16 +: 16] = pwdata[15:0];
      end else if (paddr >= `IVM_OFS_ENABLE && paddr < `IVM_OFS_ENABLE + 12'(4 * `IVM_NUM_FLAG_REGS)) begin
        r_d.en[word_idx(paddr, `IVM_OFS_ENABLE) * 16 +: 16] = pwdata[15:0];
      end else if (paddr >= `IVM_OFS_PRIO && paddr < `IVM_OFS_PRIO + 12'(4 * `IVM_NUM_PRIO_REGS)) begin
        for (int j = 0; j < 4; j++) begin
          if (word_idx(paddr, `IVM_OFS_PRIO) * 4 + j < `IVM_NUM_REQ) begin
            r_d.prio[word_idx(paddr, `IVM_OFS_PRIO) * 4 + j] = pwdata[4 * j +: 3];
          end
        end
      end
    end
    // hardware sets win over a software clear; unimplemented bits stay zero
    r_d.flag[97:0] = (r_d.flag[97:0] | src) & IMPL;
    r_d.flag[111:98] = 14'h0000;
    r_d.en[97:0] = r_d.en[97:0] & IMPL;
    r_d.en[111:98] = 14'h0000;
    r_d.trap = r_d.trap | trap_event;
    // vector offer to the cpu
    unique case (r_q.st)
      IVM_IDLE: begin
        if (hit_trap) begin
          r_d.st = IVM_OFFER;
          r_d.req = 1'b1;
          r_d.vnum = {4'h0, trap_vec};
          r_d.vaddr = vec_fetch(r_q.alt, {4'h0, trap_vec});
          r_d.vlvl = `IVM_TRAP_LEVEL;
        end else if (hit_user) begin
          r_d.st = IVM_OFFER;
          r_d.req = 1'b1;
          r_d.vnum = user_n + 7'(`IVM_USER_VEC_OFS);
          r_d.vaddr = vec_fetch(r_q.alt, user_n + 7'(`IVM_USER_VEC_OFS));
          r_d.vlvl = {1'b0, user_p};
        end
      end
      IVM_OFFER: begin
        if (cpu_ack) begin
          r_d.st = IVM_IDLE;
          r_d.req = 1'b0;
          r_d.evt[`IVM_EVT_OFFER] = 1'b1;
          if (r_q.vnum < 7'(`IVM_USER_VEC_OFS)) begin
            r_d.evt[`IVM_EVT_TRAP] = 1'b1;
          end
        end
      end
    endcase
    r_d.irq = |(r_d.evt & r_d.evt_mask);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset clears everything but the state, which loads IVM_IDLE; fetch address reads zero, not a table entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.st <= IVM_IDLE;
      r_q.vaddr <= `IVM_RESET_ADDR;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign prdata = r_q.prdata;
  assign cpu_req = r_q.req;
  assign vec_num = r_q.vnum;
  assign vec_addr = r_q.vaddr;
  assign vec_level = r_q.vlvl;
  assign irq = r_q.irq;

endmodule

// ===== verification/ivm_cpu_model.sv
// behavioural cpu core that accepts offered vectors after a chosen wait
`timescale 1ns/1ps
module ivm_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_req,
  input wire logic [3:0] ack_wait,
  output logic cpu_ack
);
  logic [3:0] wait_q;
  // one ack pulse per offer; the count restarts once the ack is out, so no double accept
  // every offered vector is accepted the same way, whatever its number or fetch address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      cpu_ack <= 1'b0;
    end else if (!cpu_req || cpu_ack) begin
      wait_q <= 4'h0;
      cpu_ack <= 1'b0;
    end else begin
      wait_q <= wait_q + 4'h1;
      cpu_ack <= (wait_q == ack_wait);
    end
  end
endmodule

// ===== verification/ivm_mapper_properties.sv
// port checker of the interrupt vector mapper
`timescale 1ns/1ps
module ivm_mapper_properties import ivm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_ack,
  input wire logic cpu_req,
  input wire logic [6:0] vec_num,
  input wire logic [23:0] vec_addr,
  input wire logic [3:0] vec_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // distance of the offered address from primary base plus twice the vector
  logic [23:0] ofs;
  assign ofs = vec_addr - 24'h00_0004 - {16'h0000, vec_num, 1'b0};
  sequence s_setup; psel && !penable ##1 psel && penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  a_apb_two_cycle: assert property (s_setup |-> s_answer) else $error("bus answer off time");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_refuse_pair: assert property (pslverr |-> pready) else $error("error without ready");
  a_entry_base: assert property (cpu_req |-> ofs == 24'h00_0000 || ofs == 24'h00_0100) else $error("bad entry");
  a_trap_slot: assert property (cpu_req && vec_num < 7'h08 |-> vec_num inside {[7'h01:7'h04]} && vec_level == 4'h8)
    else $error("bad trap offer");
  a_user_range: assert property (cpu_req && vec_num > 7'h07 |-> vec_num <= 7'h69 && vec_level inside {[4'h1:4'h7]})
    else $error("bad user offer");
  a_offer_hold: assert property (cpu_req && !cpu_ack |=> cpu_req && $stable(vec_addr) && $stable(vec_num))
    else $error("offer moved");
  a_ack_drop: assert property (cpu_req && cpu_ack |=> !cpu_req) else $error("offer kept after ack");
  a_reset_fetch: assert property ($rose(presetn) |-> vec_addr == 24'h00_0000 && !cpu_req) else $error("reset vec");
endmodule
bind ivm_mapper ivm_mapper_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cpu_ack(cpu_ack), .cpu_req(cpu_req), .vec_num(vec_num),
  .vec_addr(vec_addr), .vec_level(vec_level));

// ===== verification/interrupt_vector_mapper_tb_top.sv
// self-checking bench of the interrupt vector mapper
`timescale 1ns/1ps
`include "ivm_consts.svh"
module interrupt_vector_mapper_tb_top import ivm_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [97:0] periph_req = '0;
  logic [2:0] ext_req = 3'h0;
  logic [4:1] trap_event = 4'h0;
  logic [3:0] cpu_level = 4'h0, ack_wait = 4'h0;
  logic pready, pslverr, cpu_ack, cpu_req, irq;
  logic [31:0] prdata;
  logic [6:0] vec_num;
  logic [23:0] vec_addr;
  logic [3:0] vec_level;
  int mismatches = 0, n_tests = 0;
  // 25 MHz clock
  always #20 pclk = ~pclk;
  ivm_mapper u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .periph_req(periph_req), .external_request_zero(ext_req[0]), .external_request_one(ext_req[1]),
    .external_request_two(ext_req[2]), .trap_event(trap_event), .cpu_level(cpu_level), .cpu_ack(cpu_ack),
    .cpu_req(cpu_req), .vec_num(vec_num), .vec_addr(vec_addr), .vec_level(vec_level), .irq(irq));
  ivm_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .ack_wait(ack_wait), .cpu_ack(cpu_ack));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic stuck();
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one bus transfer; on reads d is the expected data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) stuck();
    if (!w) cmp(prdata, d);
    cmp({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_req(input logic v);
    int n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (cpu_req !== v && n < 60);
    if (n == 60) stuck();
  endtask
  task automatic offer(input logic [6:0] vn, input logic [23:0] va, input logic [3:0] lv);
    wait_req(1'b1);
    cmp({25'h0, vec_num}, {25'h0, vn});
    cmp({4'h0, vec_level, vec_addr}, {4'h0, lv, va});
  endtask
  // each trap in both tables, prompt accept
  task automatic traps();
    for (int alt = 0; alt < 2; alt++) begin
      xfer(1'b1, `IVM_OFS_CTRL, 32'(alt) << 15, 1'b0);
      for (int t = 1; t <= 4; t++) begin
        trap_event[t] <= 1'b1;
        @(posedge pclk);
        trap_event <= 4'h0;
        offer(7'(t), 24'(4 + 2 * t + 256 * alt), 4'h8);
        xfer(1'b1, `IVM_OFS_TRAP, 32'h0000_0000, 1'b0);
        wait_req(1'b0);
      end
    end
  endtask
  // named requests, slow accept, table toggled every step
  task automatic requests();
    int ids[14] = '{0, 20, 29, 11, 12, 13, 16, 17, 49, 50, 62, 65, 96, 97};
    ack_wait <= 4'hC;
    foreach (ids[i]) begin
      int n = ids[i];
      xfer(1'b1, `IVM_OFS_CTRL, 32'(i % 2) << 15, 1'b0);
      xfer(1'b1, 12'(`IVM_OFS_ENABLE + 4 * (n / 16)), 32'h1 << (n % 16), 1'b0);
      xfer(1'b1, 12'(`IVM_OFS_PRIO + 4 * (n / 4)), 32'h5 << (4 * (n % 4)), 1'b0);
      periph_req[n] <= !(n == 0 || n == 20 || n == 29);
      ext_req <= {n == 29, n == 20, n == 0};
      @(posedge pclk);
      periph_req <= '0;
      ext_req <= 3'h0;
      offer(7'(n + 8), 24'(4 + 2 * (n + 8) + 256 * (i % 2)), 4'h5);
      xfer(1'b0, 12'(`IVM_OFS_FLAG + 4 * (n / 16)), 32'h1 << (n % 16), 1'b0);
      xfer(1'b1, 12'(`IVM_OFS_FLAG + 4 * (n / 16)), 32'h0000_0000, 1'b0);
      xfer(1'b1, 12'(`IVM_OFS_ENABLE + 4 * (n / 16)), 32'h0000_0000, 1'b0);
      wait_req(1'b0);
    end
  endtask
  // requests 11 and 12 at equal level, alternate table still selected
  task automatic tie();
    xfer(1'b1, `IVM_OFS_ENABLE, 32'h0000_1800, 1'b0);
    xfer(1'b1, 12'h108, 32'h0000_2000, 1'b0);
    xfer(1'b1, 12'h10C, 32'h0000_0002, 1'b0);
    periph_req[12:11] <= 2'b11;
    @(posedge pclk);
    periph_req <= '0;
    offer(7'h13, 24'h00_012A, 4'h2);
    xfer(1'b1, `IVM_OFS_FLAG, 32'h0000_1000, 1'b0);
    wait_req(1'b0);
    offer(7'h14, 24'h00_012C, 4'h2);
    xfer(1'b1, `IVM_OFS_FLAG, 32'h0000_0000, 1'b0);
    wait_req(1'b0);
  endtask
  // accepted offers left status set: masked, unmasked, cleared
  task automatic irq_check();
    cmp({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, `IVM_OFS_EVT_MASK, 32'h0000_0001, 1'b0);
    repeat (2) @(negedge pclk);
    cmp({31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, `IVM_OFS_EVT_STAT, 32'h0000_0003, 1'b0);
    repeat (2) @(negedge pclk);
    cmp({31'h0, irq}, 32'h0000_0000);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp({7'h0, cpu_req, vec_addr}, 32'h0000_0000);
    xfer(1'b0, `IVM_OFS_CTRL, 32'h0000_0000, 1'b0);
    traps();
    requests();
    tie();
    irq_check();
    @(posedge pclk);
    periph_req[4] <= 1'b1;
    periph_req[28] <= 1'b1;
    @(posedge pclk);
    periph_req <= '0;
    xfer(1'b0, 12'h044, 32'h0000_1000, 1'b0);
    xfer(1'b1, 12'h044, 32'h0000_0000, 1'b0);
    xfer(1'b0, 12'h7FC, 32'h0000_0000, 1'b1);
    xfer(1'b1, 12'h042, 32'h0000_FFFF, 1'b1);
    xfer(1'b0, `IVM_OFS_FLAG, 32'h0000_0000, 1'b0);
    tally_and_finish();
  end
endmodule
